// [smt_pkg.sv]
package smt_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int SMT_CNT_W = 24;
    localparam int SMT_CLK_N = 8;
    localparam int SMT_SRC_N = 32;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_COUNTER = 12'h48c;
    localparam logic [11:0] IDX_CAPT_PER = 12'h48f;
    localparam logic [11:0] IDX_CAPT_PW = 12'h492;
    localparam logic [11:0] IDX_PERIOD = 12'h495;
    localparam logic [11:0] IDX_CTL0 = 12'h498;
    localparam logic [11:0] IDX_CTL1 = 12'h499;
    localparam logic [11:0] IDX_STAT = 12'h49a;
    localparam logic [11:0] IDX_CLKSEL = 12'h49b;
    localparam logic [11:0] IDX_SIGSEL = 12'h49c;
    localparam logic [11:0] IDX_WINSEL = 12'h49d;
    localparam logic [11:0] IDX_IRQ_STAT = 12'h49e;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h49f;

    // ------------------------------------------------------------
    // reset values and write masks
    // ------------------------------------------------------------
    localparam logic [23:0] COUNTER_RST = 24'h000000;
    localparam logic [23:0] PERIOD_RST = 24'hffffff;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] CTL0_WMASK = 8'hbf;
    localparam logic [7:0] CTL1_WMASK = 8'hcf;
    localparam logic [2:0] CLKSEL_WMASK = 3'h7;
    localparam logic [4:0] SRCSEL_WMASK = 5'h1f;

    // ------------------------------------------------------------
    // status and interrupt bit positions
    // ------------------------------------------------------------
    localparam int STAT_CPRUP = 7;
    localparam int STAT_CPWUP = 6;
    localparam int STAT_RST = 4;
    localparam int STAT_TS = 2;
    localparam int STAT_WS = 1;
    localparam int STAT_AS = 0;
    localparam int IRQ_MATCH = 0;
    localparam int IRQ_PRA = 1;
    localparam int IRQ_PWA = 2;

    // ------------------------------------------------------------
    // modes
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_TIMER = 4'h0;
    localparam logic [3:0] MODE_GATED = 4'h1;
    localparam logic [3:0] MODE_PERDUTY = 4'h2;
    localparam logic [3:0] MODE_HILO = 4'h3;
    localparam logic [3:0] MODE_WIN = 4'h4;
    localparam logic [3:0] MODE_GWIN = 4'h5;
    localparam logic [3:0] MODE_TOF = 4'h6;
    localparam logic [3:0] MODE_CAPT = 4'h7;
    localparam logic [3:0] MODE_CNT = 4'h8;
    localparam logic [3:0] MODE_GCNT = 4'h9;
    localparam logic [3:0] MODE_WCNT = 4'ha;

    typedef struct packed {
        logic en;
        logic rsv;
        logic halt_on_match;
        logic window_invert;
        logic signal_invert;
        logic count_clock_invert;
        logic [1:0] prescale_select;
    } smt_ctl0_s;

    typedef struct packed {
        logic go;
        logic repeat_en;
        logic [1:0] rsv;
        logic [3:0] mode;
    } smt_ctl1_s;

endpackage

// [smt_timer.sv]
`timescale 1ns/10ps
module smt_timer
    import smt_pkg::*;
#(
    parameter int CNT_W = SMT_CNT_W,
    parameter int CLK_N = SMT_CLK_N,
    parameter int SRC_N = SMT_SRC_N
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CLK_N-1:0] clk_src,
    input wire logic [SRC_N-1:0] sig_src,
    input wire logic [SRC_N-1:0] win_src,
    output logic irq
);

    function automatic logic [15:0] baddr(input logic [11:0] idx);
        baddr = {idx[13-2:0], 2'b00} | 16'h0000;
    endfunction

    function automatic logic [2:0] ps_mask(input logic [1:0] ps);
        case (ps)
            2'b00: ps_mask = 3'h0;
            2'b01: ps_mask = 3'h1;
            2'b10: ps_mask = 3'h3;
            default: ps_mask = 3'h7;
        endcase
    endfunction

    function automatic logic [23:0] lane(
        input logic [23:0] old,
        input logic [31:0] wd,
        input logic [3:0] st
    );
        lane = old;
        for (int i = 0; i < 3; i++)
        begin
            if (st[i])
                lane[8*i +: 8] = wd[8*i +: 8];
        end
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [CNT_W-1:0] counter_value_reg;
    logic [CNT_W-1:0] captured_period_reg;
    logic [CNT_W-1:0] captured_pulse_width_reg;
    logic [CNT_W-1:0] match_period_reg;
    smt_ctl0_s control_primary_reg;
    smt_ctl1_s control_secondary_reg;
    logic cprup_reg;
    logic cpwup_reg;
    logic manual_rst_reg;
    logic [2:0] clock_source_select_reg;
    logic [4:0] signal_source_select_reg;
    logic [4:0] window_source_select_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;

    // ------------------------------------------------------------
    // apb slave: one wait state, answer from flip-flops
    // ------------------------------------------------------------
    logic acc;
    logic wr;
    logic hit;

    assign acc = psel & penable & ~pready;
    assign wr = psel & penable & pready & pwrite;

    always_comb
    begin
        hit = 1'b1;
        case (paddr)
            baddr(IDX_COUNTER), baddr(IDX_CAPT_PER),
            baddr(IDX_CAPT_PW), baddr(IDX_PERIOD),
            baddr(IDX_CTL0), baddr(IDX_CTL1),
            baddr(IDX_STAT), baddr(IDX_CLKSEL),
            baddr(IDX_SIGSEL), baddr(IDX_WINSEL),
            baddr(IDX_IRQ_STAT), baddr(IDX_IRQ_MASK): hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    logic wr_cnt;
    logic wr_per;
    logic wr_c0;
    logic wr_c1;
    logic wr_st;
    logic wr_sel;
    logic wr_is;
    logic wr_im;

    assign wr_cnt = wr & (paddr == baddr(IDX_COUNTER));
    assign wr_per = wr & (paddr == baddr(IDX_PERIOD));
    assign wr_c0 = wr & (paddr == baddr(IDX_CTL0)) & pstrb[0];
    assign wr_c1 = wr & (paddr == baddr(IDX_CTL1)) & pstrb[0];
    assign wr_st = wr & (paddr == baddr(IDX_STAT)) & pstrb[0];
    assign wr_sel = wr & pstrb[0];
    assign wr_is = wr & (paddr == baddr(IDX_IRQ_STAT)) & pstrb[0];
    assign wr_im = wr & (paddr == baddr(IDX_IRQ_MASK)) & pstrb[0];

    logic ts;
    logic ws;
    logic as_now;
    logic [7:0] stat_rd;

    assign stat_rd = {cprup_reg, cpwup_reg, 1'b0, manual_rst_reg,
        1'b0, ts, ws, as_now};

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= acc;
            pslverr <= acc & ~hit;
            if (acc & ~pwrite)
            begin
                case (paddr)
                    baddr(IDX_COUNTER): prdata <= {8'h00, counter_value_reg};
                    baddr(IDX_CAPT_PER):
                        prdata <= {8'h00, captured_period_reg};
                    baddr(IDX_CAPT_PW):
                        prdata <= {8'h00, captured_pulse_width_reg};
                    baddr(IDX_PERIOD): prdata <= {8'h00, match_period_reg};
                    baddr(IDX_CTL0): prdata <= {24'h0, control_primary_reg};
                    baddr(IDX_CTL1):
                        prdata <= {24'h000000, control_secondary_reg};
                    baddr(IDX_STAT): prdata <= {24'h000000, stat_rd};
                    baddr(IDX_CLKSEL):
                        prdata <= {29'h0, clock_source_select_reg};
                    baddr(IDX_SIGSEL):
                        prdata <= {27'h0, signal_source_select_reg};
                    baddr(IDX_WINSEL):
                        prdata <= {27'h0, window_source_select_reg};
                    baddr(IDX_IRQ_STAT): prdata <= {29'h0, irq_stat_reg};
                    baddr(IDX_IRQ_MASK): prdata <= {29'h0, irq_mask_reg};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // input synchronisers: a rise or a fall counts once stages 2 and 3 agree; the filter holds while they differ
    // ------------------------------------------------------------
    localparam int SYN_W = CLK_N + 2 * SRC_N;
    logic [SYN_W-1:0] s1_reg;
    logic [SYN_W-1:0] s2_reg;
    logic [SYN_W-1:0] s3_reg;
    logic [SYN_W-1:0] filt_reg;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            filt_reg <= '0;
        end
        else
        begin
            s1_reg <= {win_src, sig_src, clk_src};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= (filt_reg & ~(s2_reg ^ s3_reg))
                | (s3_reg & ~(s2_reg ^ s3_reg));
        end
    end

    // ------------------------------------------------------------
    // source select, polarity and edges
    // ------------------------------------------------------------
    logic clk_lvl;
    logic sig_act;
    logic win_act;
    logic clk_q;
    logic sig_q;
    logic win_q;

    assign clk_lvl = filt_reg[clock_source_select_reg]
        ^ control_primary_reg.count_clock_invert;
    assign sig_act = filt_reg[CLK_N + signal_source_select_reg]
        ^ control_primary_reg.signal_invert;
    assign win_act = filt_reg[CLK_N + SRC_N + window_source_select_reg]
        ^ control_primary_reg.window_invert;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_q <= 1'b0;
            sig_q <= 1'b0;
            win_q <= 1'b0;
        end
        else
        begin
            clk_q <= clk_lvl;
            sig_q <= sig_act;
            win_q <= win_act;
        end
    end

    logic en;
    logic run;
    logic clk_edge;
    logic sig_rise;
    logic sig_fall;
    logic win_rise;
    logic win_fall;

    assign en = control_primary_reg.en;
    assign run = en & control_secondary_reg.go;
    assign clk_edge = clk_lvl & ~clk_q;
    assign sig_rise = sig_act & ~sig_q;
    assign sig_fall = ~sig_act & sig_q;
    assign win_rise = win_act & ~win_q;
    assign win_fall = ~win_act & win_q;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic [2:0] ps_cnt_reg;
    logic tick;

    assign tick = clk_edge & en
        & (ps_cnt_reg == ps_mask(control_primary_reg.prescale_select));

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ps_cnt_reg <= 3'h0;
        else if (!en)
            ps_cnt_reg <= 3'h0;
        else if (tick)
            ps_cnt_reg <= 3'h0;
        else if (clk_edge)
            ps_cnt_reg <= ps_cnt_reg + 3'h1;
    end

    // ------------------------------------------------------------
    // acquisition decode per mode
    // ------------------------------------------------------------
    logic armed_reg;
    logic pend_reg;
    logic inc;
    logic cap_r;
    logic cap_w;
    logic clr;
    logic done;
    logic armed_next;
    logic [CNT_W-1:0] clr_val;

    always_comb
    begin
        inc = 1'b0;
        cap_r = 1'b0;
        cap_w = 1'b0;
        clr = 1'b0;
        clr_val = '0;
        armed_next = armed_reg;
        case (control_secondary_reg.mode)
            MODE_TIMER: inc = tick;
            MODE_GATED:
            begin
                inc = tick & sig_act;
                cap_w = sig_fall;
            end
            MODE_PERDUTY:
            begin
                inc = tick;
                cap_w = sig_fall;
                cap_r = sig_rise;
                clr = sig_rise;
                clr_val = CNT_W'(1);
            end
            MODE_HILO:
            begin
                inc = tick & armed_reg;
                armed_next = armed_reg | sig_rise;
                cap_w = armed_reg & sig_fall;
                cap_r = armed_reg & sig_rise;
                clr = cap_w | cap_r;
            end
            MODE_WIN, MODE_GWIN:
            begin
                inc = tick & armed_reg
                    & (control_secondary_reg.mode == MODE_WIN | sig_act);
                armed_next = armed_reg | win_rise;
                cap_r = armed_reg & win_rise;
                clr = cap_r;
            end
            MODE_TOF:
            begin
                inc = tick & armed_reg;
                cap_r = armed_reg & sig_rise;
                cap_w = armed_reg & win_rise & ~sig_rise;
                clr = cap_r | cap_w | (win_rise & ~armed_reg);
                armed_next = (armed_reg & ~sig_rise) | win_rise;
            end
            MODE_CAPT:
            begin
                inc = tick;
                cap_r = win_rise;
                cap_w = win_fall;
            end
            MODE_CNT:
            begin
                inc = sig_rise;
                cap_w = win_fall;
            end
            MODE_GCNT:
            begin
                inc = sig_rise & win_act;
                cap_w = win_fall;
            end
            MODE_WCNT:
            begin
                inc = sig_rise & armed_reg;
                armed_next = armed_reg | win_rise;
                cap_w = armed_reg & win_fall;
                cap_r = armed_reg & win_rise;
                clr = cap_r;
            end
            default: inc = 1'b0;
        endcase
        if (!run)
        begin
            inc = 1'b0;
            cap_r = 1'b0;
            cap_w = 1'b0;
            clr = 1'b0;
            armed_next = armed_reg;
        end
    end

    // single acquisition ends on the period capture, or on the width
    // capture in modes that never take a period
    assign done = ~control_secondary_reg.repeat_en
        & (cap_r | (cap_w & (control_secondary_reg.mode == MODE_GATED
        | control_secondary_reg.mode == MODE_CNT
        | control_secondary_reg.mode == MODE_GCNT)));
    assign ts = run;
    assign ws = win_act;
    assign as_now = sig_act;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            armed_reg <= 1'b0;
        else if (!en || !control_secondary_reg.go)
            armed_reg <= 1'b0;
        else
            armed_reg <= armed_next;
    end

    // ------------------------------------------------------------
    // counter and period match
    // ------------------------------------------------------------
    logic match;

    assign match = counter_value_reg == match_period_reg;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            counter_value_reg <= COUNTER_RST;
        else if (wr_cnt)
            counter_value_reg <= lane(counter_value_reg, pwdata, pstrb);
        else if (manual_rst_reg)
            counter_value_reg <= '0;
        else if (clr)
            counter_value_reg <= clr_val;
        else if (inc && match && control_primary_reg.halt_on_match)
            counter_value_reg <= match_period_reg;
        else if (inc && match)
            counter_value_reg <= '0;
        else if (inc)
            counter_value_reg <= counter_value_reg + CNT_W'(1);
    end

    // the interrupt follows on the counting clock after the match
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            pend_reg <= 1'b0;
        else if (!en)
            pend_reg <= 1'b0;
        else if (inc)
            pend_reg <= match;
    end

    // no reset: contents survive every reset
    always_ff @(posedge ref_clk)
    begin
        if (cap_r || cprup_reg)
            captured_period_reg <= counter_value_reg;
        if (cap_w || cpwup_reg)
            captured_pulse_width_reg <= counter_value_reg;
    end

    // ------------------------------------------------------------
    // control and select registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            match_period_reg <= PERIOD_RST;
            control_primary_reg <= CTL_RST;
            control_secondary_reg <= CTL_RST;
            clock_source_select_reg <= '0;
            signal_source_select_reg <= '0;
            window_source_select_reg <= '0;
            irq_mask_reg <= '0;
        end
        else
        begin
            if (wr_per)
                match_period_reg <= lane(match_period_reg, pwdata, pstrb);
            if (wr_c0)
                control_primary_reg <= pwdata[7:0] & CTL0_WMASK;
            if (wr_c1)
                control_secondary_reg <= pwdata[7:0] & CTL1_WMASK;
            else if (done)
                control_secondary_reg.go <= 1'b0;
            if (wr_sel && paddr == baddr(IDX_CLKSEL))
                clock_source_select_reg <= pwdata[2:0] & CLKSEL_WMASK;
            if (wr_sel && paddr == baddr(IDX_SIGSEL))
                signal_source_select_reg <= pwdata[4:0] & SRCSEL_WMASK;
            if (wr_sel && paddr == baddr(IDX_WINSEL))
                window_source_select_reg <= pwdata[4:0] & SRCSEL_WMASK;
            if (wr_im)
                irq_mask_reg <= pwdata[2:0];
        end
    end

    // manual update requests clear themselves after one cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cprup_reg <= 1'b0;
            cpwup_reg <= 1'b0;
            manual_rst_reg <= 1'b0;
        end
        else
        begin
            cprup_reg <= wr_st & pwdata[STAT_CPRUP];
            cpwup_reg <= wr_st & pwdata[STAT_CPWUP];
            manual_rst_reg <= wr_st & pwdata[STAT_RST];
        end
    end

    // ------------------------------------------------------------
    // interrupts: set beats a write-one clear in the same cycle
    // ------------------------------------------------------------
    logic [2:0] irq_set;

    assign irq_set = {cap_w, cap_r, inc & pend_reg};

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_stat_reg <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= (irq_stat_reg & ~({3{wr_is}} & pwdata[2:0]))
                | irq_set;
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

endmodule

// [smt_timer_monitor.sv]
`timescale 1ns/10ps
module smt_timer_monitor
    import smt_pkg::*;
#(
    parameter int CNT_W = SMT_CNT_W,
    parameter int CLK_N = SMT_CLK_N,
    parameter int SRC_N = SMT_SRC_N
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [CLK_N-1:0] clk_src,
    input wire logic [SRC_N-1:0] sig_src,
    input wire logic [SRC_N-1:0] win_src,
    input wire logic irq
);
    // ----------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------
    logic wait_st;
    logic wr_done;
    logic hit;
    assign wait_st = psel && penable && !pready;
    assign wr_done = psel && penable && pready && pwrite;
    // only aligned words with clear top bits map onto a register
    assign hit = paddr[15:14] == 2'h0 && paddr[1:0] == 2'h0
        && paddr[13:2] inside {IDX_COUNTER, IDX_CAPT_PER, IDX_CAPT_PW,
        IDX_PERIOD, IDX_CTL0, IDX_CTL1, IDX_STAT, IDX_CLKSEL, IDX_SIGSEL,
        IDX_WINSEL, IDX_IRQ_STAT, IDX_IRQ_MASK};

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------------------------
    // properties
    // ----------------------------------------------------------
    property p_wait;
        wait_st |=> pready;
    endproperty
    a_wait: assert property (p_wait)
        else $error("no answer one cycle after access");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("ready longer than one cycle");
    property p_idle;
        !psel |=> !pready;
    endproperty
    a_idle: assert property (p_idle)
        else $error("ready without a transfer");
    property p_err;
        wait_st && paddr[1:0] == 2'b00 && !hit |=> pready && pslverr;
    endproperty
    a_err: assert property (p_err)
        else $error("unmapped access not refused");
    property p_ok;
        wait_st && hit |=> pready && !pslverr;
    endproperty
    a_ok: assert property (p_ok)
        else $error("mapped access refused");
    property p_hold;
        (!psel || pwrite) |=> $stable(prdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved without a read");
    property p_irq_fall;
        $fell(irq) |-> $past(wr_done) || $past(wr_done, 2)
            || $past(wr_done, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without a write");
    property p_irq_rst;
        $fell(rst) |-> !irq;
    endproperty
    a_irq_rst: assert property (p_irq_rst)
        else $error("interrupt high after reset");
endmodule

bind smt_timer smt_timer_monitor #(.CNT_W(CNT_W), .CLK_N(CLK_N),
    .SRC_N(SRC_N)) u_mon (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_src(clk_src), .sig_src(sig_src), .win_src(win_src), .irq(irq));

// [smt_timer_bench.sv]
`timescale 1ns/10ps
module smt_timer_bench
    import smt_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, r, p;
    logic [3:0] pstrb = 4'hf;
    logic [SMT_CLK_N-1:0] clk_src = '0;
    logic [SMT_SRC_N-1:0] sig_src = '0, win_src = '0;
    logic [1:0] div = 2'b00;
    logic e;
    int error_cnt = 0, samples_checked = 0, cyc_cnt = 0;

    smt_timer DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clk_src(clk_src), .sig_src(sig_src), .win_src(win_src), .irq(irq));

    // ----------------------------------------------------------
    // clocks and watchdog
    // ----------------------------------------------------------
    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end
    // count clock at ref_clk/8, half the fastest even-duty clock the input filter accepts
    always @(posedge ref_clk)
    begin
        div <= div + 2'h1;
        if (div == 2'h3)
            clk_src[0] <= ~clk_src[0];
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 10000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, x);
        samples_checked++;
        if (s !== x)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] i,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] i, input logic [31:0] d);
        apb(1'b1, i, d, 4'hf);
    endtask
    task automatic rd(input logic [11:0] i);
        apb(1'b0, i, 32'h0, 4'hf);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_regs;
        rd(IDX_COUNTER);
        chk("counter reset", r, 32'h0);
        rd(IDX_PERIOD);
        chk("period reset", r, 32'hffffff);
        wr(IDX_COUNTER, 32'h123456);
        apb(1'b1, IDX_COUNTER, 32'h0000aa, 4'h1);
        apb(1'b1, IDX_COUNTER, 32'h00ff0000, 4'h4);
        rd(IDX_COUNTER);
        chk("counter lanes", r, 32'hff34aa);
        rd(12'h400);
        chk("unmapped err", e, 1'b1);
        chk("unmapped data", r, 32'h0);
    endtask
    task automatic t_wrap;
        wr(IDX_PERIOD, 32'h3);
        wr(IDX_IRQ_MASK, 32'h7);
        wr(IDX_CTL1, 32'hc0);
        wr(IDX_COUNTER, 32'h0);
        wr(IDX_CTL0, 32'h80);
        cyc(200);
        repeat (6)
        begin
            rd(IDX_COUNTER);
            chk("wrap", r <= 3, 1'b1);
        end
        wr(IDX_CTL1, 32'h40);
        cyc(20);
        chk("irq match", irq, 1'b1);
        wr(IDX_IRQ_MASK, 32'h6);
        cyc(3);
        chk("irq masked", irq, 1'b0);
        wr(IDX_IRQ_MASK, 32'h7);
        wr(IDX_IRQ_STAT, 32'h1);
        cyc(3);
        chk("irq cleared", irq, 1'b0);
    endtask
    task automatic t_halt;
        wr(IDX_CTL0, 32'ha0);
        wr(IDX_COUNTER, 32'h0);
        wr(IDX_CTL1, 32'hc0);
        cyc(200);
        rd(IDX_COUNTER);
        chk("halt", r, 32'h3);
        rd(IDX_IRQ_STAT);
        chk("halt irq", r[0], 1'b1);
        wr(IDX_CTL0, 32'h0);
        cyc(40);
        rd(IDX_COUNTER);
        chk("disabled holds", r, 32'h3);
        rd(IDX_STAT);
        chk("disabled idle", r[STAT_TS], 1'b0);
    endtask
    task automatic t_prescale;
        wr(IDX_PERIOD, 32'hffffff);
        for (int ps = 0; ps < 4; ps++)
        begin
            wr(IDX_CTL0, 32'h80 | ps);
            wr(IDX_COUNTER, 32'h0);
            cyc(320);
            rd(IDX_COUNTER);
            p = 40 >> ps;
            chk("prescale", r + 2 >= p && r <= p + 2, 1'b1);
        end
    endtask
    task automatic t_capture;
        wr(IDX_CTL1, 32'hc7);
        wr(IDX_IRQ_STAT, 32'h7);
        win_src[0] <= 1'b1;
        cyc(20);
        rd(IDX_IRQ_STAT);
        chk("period capt", r[2:0], 3'b010);
        rd(IDX_CAPT_PER);
        p = r;
        wr(IDX_CAPT_PER, 32'h0);
        rd(IDX_CAPT_PER);
        chk("cpr read only", r, p);
        win_src[0] <= 1'b0;
        cyc(20);
        rd(IDX_IRQ_STAT);
        chk("width capt", r[2:1], 2'b11);
        rd(IDX_CAPT_PW);
        chk("cpw order", r >= p, 1'b1);
        wr(IDX_CTL0, 32'h90);
        cyc(20);
        wr(IDX_IRQ_STAT, 32'h7);
        win_src[0] <= 1'b1;
        cyc(20);
        rd(IDX_IRQ_STAT);
        chk("window invert", r[2:1], 2'b10);
        wr(IDX_CTL1, 32'h87);
        win_src[0] <= 1'b0;
        cyc(20);
        rd(IDX_STAT);
        chk("single stops", r[STAT_TS], 1'b0);
        rd(IDX_CAPT_PER);
        p = r;
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        rd(IDX_CAPT_PER);
        chk("cpr kept", r, p);
    endtask
    task automatic t_gate;
        for (int inv = 0; inv < 3; inv++)
        begin
            wr(IDX_CTL0, inv == 0 ? 32'h80 : 32'h88);
            wr(IDX_CTL1, inv == 2 ? 32'h41 : 32'hc1);
            wr(IDX_COUNTER, 32'h0);
            cyc(100);
            rd(IDX_COUNTER);
            chk("gated", r != 0, inv == 1);
        end
    endtask

    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_wrap();
        t_halt();
        t_prescale();
        t_capture();
        t_gate();
        end_of_test();
    end
endmodule
